// >>> hdl/sar_dev.sv
// Function
// R1: low power_down_control means shutdown, else normal
// R2: conversion starts only on select_n fall
// R3: marker high then 10 bits MSB first
// R4: select_n fall freezes the input sample
// R5: internal timing; serial_out high marks end
// R6: whole conversion takes 9 us
// R7: host waits 1.5 us acquisition between conversions
// R8: high enables internal reference; floating disables it
// R9: host waits 20 ms after power-up
// R10: external reference: host waits 10 us reset
// R11: host waits wake time after shutdown release
// R12: host reads at up to 2.1 MHz
// R13: shift_clock phases each at least 200 ns
// R14: shift_clock idle during conversion
// R15: change on falling edges; 13 edges per frame
// R16: extra falling edges shift out zeros
// R17: select_n fall drives serial_out low
// R18: after abort host waits acquisition time
// R19: select_n high: output released, clock ignored
`timescale 1ns/1ps
`default_nettype none
module sar_dev
	import sar_pkg::*;
#(
	parameter int RES_W = RES_BITS,
	parameter int DEPTH = BUF_DEPTH
) (
	input wire logic clk,
	input wire logic clk_en,
	input wire logic rst_n,
	sar_link_if.dev link,
	input wire logic [RES_W-1:0] analog_input,
	output logic track_hold,
	output logic internal_ref_en,
	output logic shutdown,
	output logic busy
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_BUF_W = $clog2(DEPTH + 1);
	localparam int SH_W = RES_W + SUB_BITS;

	// ****************************************************************
	// pin synchronisers and edges
	// ****************************************************************
	logic [3:0] in_meta_q;
	logic [3:0] in_sync_q;
	logic sel_prev_q;
	logic sck_prev_q;
	logic sel_fall;
	logic sel_rise;
	logic sck_fall;
	logic pwr_down;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			in_meta_q <= IN_SYNC_RST;
			in_sync_q <= IN_SYNC_RST;
			sel_prev_q <= IN_SYNC_RST[3];
			sck_prev_q <= IN_SYNC_RST[2];
		end
		else if (clk_en)
		begin
			in_meta_q <= {link.select_n, link.shift_clock, link.pdc_level, link.pdc_float};
			in_sync_q <= in_meta_q;
			sel_prev_q <= in_sync_q[3];
			sck_prev_q <= in_sync_q[2];
		end
	end

	assign sel_fall = sel_prev_q && !in_sync_q[3];
	assign sel_rise = !sel_prev_q && in_sync_q[3];
	assign sck_fall = sck_prev_q && !in_sync_q[2];
	assign pwr_down = !in_sync_q[1]; // see R1

	// ****************************************************************
	// mode outputs
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			shutdown <= 1'b0;
			internal_ref_en <= 1'b0;
		end
		else if (clk_en)
		begin
			shutdown <= pwr_down; // see R1
			internal_ref_en <= !pwr_down && !in_sync_q[0]; // see R8
		end
	end

	// ****************************************************************
	// result buffer between converter and shifter
	// ****************************************************************
	logic [RES_W-1:0] buf_mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [CNT_BUF_W-1:0] buf_cnt_q;
	logic buf_in_valid;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic buf_flush;

	function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
		return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
	endfunction : ptr_next

	assign buf_in_ready = buf_cnt_q != CNT_BUF_W'(DEPTH);
	assign buf_out_valid = buf_cnt_q != '0;

	always_ff @(posedge clk)
	begin
		if (!rst_n || (clk_en && buf_flush))
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			buf_cnt_q <= '0;
		end
		else if (clk_en)
		begin
			if (buf_in_valid && buf_in_ready)
				wr_ptr_q <= ptr_next(wr_ptr_q);
			if (buf_out_valid && buf_out_ready)
				rd_ptr_q <= ptr_next(rd_ptr_q);
			buf_cnt_q <= buf_cnt_q + CNT_BUF_W'(buf_in_valid && buf_in_ready)
				- CNT_BUF_W'(buf_out_valid && buf_out_ready);
		end
	end

	// ****************************************************************
	// conversion sequencer
	// ****************************************************************
	sar_dev_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] step_q;
	logic [RES_W-1:0] sample_q;
	logic [RES_W-1:0] res_q;
	logic [RES_W-1:0] bit_q;
	logic [SH_W-1:0] sh_q;

	assign buf_flush = sel_rise;
	assign buf_in_valid = (state_q == DEV_PUSH);
	assign buf_out_ready = (state_q == DEV_LOAD);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			buf_mem[0] <= '0;
		else if (clk_en && buf_in_valid && buf_in_ready)
			buf_mem[wr_ptr_q] <= res_q;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_q <= DEV_IDLE;
			cnt_q <= '0;
			step_q <= '0;
			sample_q <= '0;
			res_q <= '0;
			bit_q <= '0;
		end
		else if (clk_en)
		begin
			if (sel_rise)
				state_q <= DEV_IDLE; // see R19
			else
			begin
				case (state_q)
					DEV_IDLE:
						if (sel_fall && !pwr_down) // see R2
						begin
							sample_q <= analog_input; // see R4
							res_q <= '0;
							bit_q <= {1'b1, {(RES_W-1){1'b0}}};
							cnt_q <= '0;
							step_q <= '0;
							state_q <= DEV_CONV;
						end
					DEV_CONV:
					begin
						cnt_q <= cnt_q + CNT_W'(1);
						if (step_q == CNT_W'(STEP_CYC - 1))
						begin
							step_q <= '0;
							if (bit_q != '0)
							begin
								if (sample_q >= (res_q | bit_q))
									res_q <= res_q | bit_q;
								bit_q <= bit_q >> 1;
							end
						end
						else
							step_q <= step_q + CNT_W'(1);
						if (cnt_q == CNT_W'(CONV_CYC - 1)) // see R6
							state_q <= DEV_PUSH;
					end
					DEV_PUSH:
						if (buf_in_ready)
							state_q <= DEV_LOAD;
					DEV_LOAD:
						if (buf_out_valid)
							state_q <= DEV_SHIFT;
					DEV_SHIFT:
						state_q <= DEV_SHIFT; // see R16
					default:
						state_q <= DEV_IDLE;
				endcase
			end
		end
	end

	// ****************************************************************
	// serial output
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			link.serial_out_o <= 1'b0;
			link.serial_out_oe_n <= 1'b1;
			sh_q <= '0;
		end
		else if (clk_en)
		begin
			if (sel_rise)
				link.serial_out_oe_n <= 1'b1; // see R19
			else if (state_q == DEV_IDLE && sel_fall && !pwr_down)
			begin
				link.serial_out_o <= 1'b0; // see R17
				link.serial_out_oe_n <= 1'b0;
			end
			else if (state_q == DEV_LOAD && buf_out_valid)
			begin
				link.serial_out_o <= 1'b1; // see R5
				sh_q <= {buf_mem[rd_ptr_q], SUB_BITS_FILL}; // see R3
			end
			else if (state_q == DEV_SHIFT && sck_fall) // see R15
			begin
				link.serial_out_o <= sh_q[SH_W-1];
				sh_q <= {sh_q[SH_W-2:0], 1'b0}; // see R16
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			track_hold <= 1'b0;
			busy <= 1'b0;
		end
		else if (clk_en)
		begin
			track_hold <= (state_q == DEV_CONV) || (state_q == DEV_PUSH);
			busy <= state_q != DEV_IDLE;
		end
	end

endmodule : sar_dev
`default_nettype wire

// >>> hdl/sar_host.sv
`timescale 1ns/1ps
`default_nettype none
module sar_host
	import sar_pkg::*;
#(
	parameter int RES_W = RES_BITS,
	parameter int DEPTH = BUF_DEPTH,
	parameter int PWRUP_CYC = POWERUP_CYC
) (
	input wire logic clk,
	input wire logic clk_en,
	input wire logic rst_n,
	sar_link_if.host link,
	input wire logic start_req,
	input wire logic use_internal_ref,
	input wire logic sleep_req,
	output logic [RES_W-1:0] result_data,
	output logic result_valid,
	input wire logic result_ready,
	output logic busy
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_BUF_W = $clog2(DEPTH + 1);
	localparam int EDGE_W = $clog2(FRAME_EDGES + 1);

	// ****************************************************************
	// serial_out synchroniser
	// ****************************************************************
	logic sdo_meta_q;
	logic sdo_sync_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sdo_meta_q <= 1'b0;
			sdo_sync_q <= 1'b0;
		end
		else if (clk_en)
		begin
			sdo_meta_q <= link.serial_out;
			sdo_sync_q <= sdo_meta_q;
		end
	end

	// ****************************************************************
	// result buffer toward the user
	// ****************************************************************
	logic [RES_W-1:0] buf_mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [CNT_BUF_W-1:0] buf_cnt_q;
	logic buf_push;
	logic buf_pop;
	logic buf_in_ready;
	logic [FRAME_EDGES-1:0] rx_q;

	function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
		return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
	endfunction : ptr_next

	assign buf_in_ready = buf_cnt_q != CNT_BUF_W'(DEPTH);
	assign result_valid = buf_cnt_q != '0;
	assign buf_pop = result_valid && result_ready;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			buf_cnt_q <= '0;
		end
		else if (clk_en)
		begin
			if (buf_push)
				wr_ptr_q <= ptr_next(wr_ptr_q);
			if (buf_pop)
				rd_ptr_q <= ptr_next(rd_ptr_q);
			buf_cnt_q <= buf_cnt_q + CNT_BUF_W'(buf_push) - CNT_BUF_W'(buf_pop);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			buf_mem[0] <= '0;
		else if (clk_en && buf_push)
			buf_mem[wr_ptr_q] <= rx_q[SUB_BITS +: RES_W];
	end

	assign result_data = buf_mem[rd_ptr_q];

	// ****************************************************************
	// frame sequencer
	// ****************************************************************
	sar_hst_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [EDGE_W-1:0] edges_q;
	logic frame_end;

	assign frame_end = (state_q == HST_SHIFT) && link.shift_clock
		&& (cnt_q == CNT_W'(SCK_HALF_CYC - 1)) && (edges_q == EDGE_W'(FRAME_EDGES - 1));
	assign buf_push = clk_en && frame_end && buf_in_ready;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_q <= HST_POWERUP;
			cnt_q <= '0;
			edges_q <= '0;
			rx_q <= '0;
			link.select_n <= 1'b1;
			link.shift_clock <= 1'b0;
		end
		else if (clk_en)
		begin
			cnt_q <= cnt_q + CNT_W'(1);
			case (state_q)
				HST_POWERUP, HST_WAKE:
					if (cnt_q >= CNT_W'(state_q == HST_WAKE ? (use_internal_ref ? PWRUP_CYC : WAKE_CYC)
						: (use_internal_ref ? PWRUP_CYC : EXT_RESET_CYC))) // see R9 R10 R11
					begin
						state_q <= HST_IDLE;
					end
				HST_IDLE:
				begin
					cnt_q <= '0;
					if (sleep_req)
						state_q <= HST_SLEEP;
					else if (start_req && buf_in_ready)
					begin
						link.select_n <= 1'b0; // see R2
						state_q <= HST_CONV;
					end
				end
				HST_SLEEP:
				begin
					cnt_q <= '0;
					if (!sleep_req)
						state_q <= HST_WAKE;
				end
				HST_CONV: // see R14
					if (sdo_sync_q || cnt_q >= CNT_W'(EOC_TIMEOUT_CYC)) // see R5 R6
					begin
						cnt_q <= '0;
						edges_q <= '0;
						state_q <= HST_SHIFT;
					end
				HST_SHIFT:
					if (cnt_q == CNT_W'(SCK_HALF_CYC - 1)) // see R12 R13
					begin
						cnt_q <= '0;
						link.shift_clock <= !link.shift_clock;
						if (!link.shift_clock)
							rx_q <= {rx_q[FRAME_EDGES-2:0], sdo_sync_q};
						else if (frame_end) // see R15
						begin
							link.select_n <= 1'b1;
							state_q <= HST_ACQ;
						end
						else
							edges_q <= edges_q + EDGE_W'(1);
					end
				HST_ACQ:
					if (cnt_q >= CNT_W'(ACQ_CYC)) // see R7 R18
						state_q <= HST_IDLE;
				default:
					state_q <= HST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// three-level power-down drive
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			link.pdc_o <= 1'b1;
			link.pdc_oe_n <= 1'b1;
			busy <= 1'b1;
		end
		else if (clk_en)
		begin
			link.pdc_o <= state_q != HST_SLEEP; // see R1
			link.pdc_oe_n <= !(state_q == HST_SLEEP || use_internal_ref); // see R8
			busy <= state_q != HST_IDLE;
		end
	end

endmodule : sar_host
`default_nettype wire

// >>> hdl/sar_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
	logic select_n;
	logic shift_clock;
	logic serial_out_o;
	logic serial_out_oe_n;
	logic pdc_o;
	logic pdc_oe_n;
	// ****************************************************************
	// resolved wire levels
	// ****************************************************************
	logic serial_out;
	logic pdc_level;
	logic pdc_float;
	// weak pull-down on serial_out, weak pull-up on power_down_control
	assign serial_out = serial_out_oe_n ? 1'b0 : serial_out_o;
	assign pdc_level = pdc_oe_n ? 1'b1 : pdc_o;
	assign pdc_float = pdc_oe_n;

	modport dev (
		input select_n, shift_clock, pdc_level, pdc_float,
		output serial_out_o, serial_out_oe_n
	);
	modport host (
		input serial_out,
		output select_n, shift_clock, pdc_o, pdc_oe_n
	);
endinterface : sar_link_if
`default_nettype wire

// >>> hdl/sar_pkg.sv
package sar_pkg;

	// ****************************************************************
	// widths and frame layout
	// ****************************************************************
	localparam int RES_BITS = 10;
	localparam int SUB_BITS = 2;
	localparam int FRAME_EDGES = 1 + RES_BITS + SUB_BITS;
	localparam int BUF_DEPTH = 2;
	localparam int CNT_W = 24;
	localparam logic [SUB_BITS-1:0] SUB_BITS_FILL = 2'h0;
	// select_n, shift_clock, pdc level, pdc floating
	localparam logic [3:0] IN_SYNC_RST = 4'hA;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int CONV_TIME_NS = 9000;
	localparam int ACQ_TIME_NS = 1500;
	localparam int WAKE_TIME_NS = 4000;
	localparam int EXT_RESET_NS = 10000;
	localparam int POWERUP_TIME_MS = 20;
	localparam int SCK_PHASE_MIN_NS = 200;
	localparam int SCK_MAX_KHZ = 2100;
	localparam int EOC_MARGIN_CYC = 8;

	function automatic int ceil_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ceil_cyc

	function automatic int floor_cyc(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : floor_cyc

	function automatic int max_int(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : max_int

	localparam int CONV_CYC = floor_cyc(CONV_TIME_NS);
	localparam int STEP_CYC = CONV_CYC / (RES_BITS + 1);
	localparam int ACQ_CYC = ceil_cyc(ACQ_TIME_NS);
	localparam int WAKE_CYC = ceil_cyc(WAKE_TIME_NS);
	localparam int EXT_RESET_CYC = ceil_cyc(EXT_RESET_NS);
	localparam int POWERUP_CYC = POWERUP_TIME_MS * 1000000 / CLK_PERIOD_NS;
	// half period in ns rounded up: 1e6 / (2 * kHz)
	localparam int SCK_HALF_NS = (1000000 + 2 * SCK_MAX_KHZ - 1) / (2 * SCK_MAX_KHZ);
	localparam int SCK_HALF_CYC = max_int(ceil_cyc(SCK_PHASE_MIN_NS), ceil_cyc(SCK_HALF_NS));
	localparam int EOC_TIMEOUT_CYC = CONV_CYC + EOC_MARGIN_CYC;

	// ****************************************************************
	// states
	// ****************************************************************
	typedef enum logic [2:0] {
		DEV_IDLE = 3'b000,
		DEV_CONV = 3'b001,
		DEV_PUSH = 3'b010,
		DEV_LOAD = 3'b011,
		DEV_SHIFT = 3'b100
	} sar_dev_state_t;

	typedef enum logic [2:0] {
		HST_POWERUP = 3'b000,
		HST_IDLE = 3'b001,
		HST_CONV = 3'b010,
		HST_SHIFT = 3'b011,
		HST_ACQ = 3'b100,
		HST_SLEEP = 3'b101,
		HST_WAKE = 3'b110
	} sar_hst_state_t;

endpackage : sar_pkg

// >>> verification/sar_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sar_link_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic select_n,
	input wire logic shift_clock,
	input wire logic serial_out_o,
	input wire logic serial_out_oe_n,
	input wire logic serial_out,
	input wire logic pdc_o,
	input wire logic pdc_oe_n
);
	logic [4:0] rise_q;
	logic [5:0] high_q;
	logic conv_q;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ****
	// rising shift edges in a frame, cycles with select high
	// ****
	always_ff @(posedge clk)
	begin
		if (!rst_n || select_n)
			rise_q <= 5'h00;
		else if ($rose(shift_clock))
			rise_q <= rise_q + 5'h01;
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n || !select_n)
			high_q <= 6'h00;
		else if (high_q != 6'h3f)
			high_q <= high_q + 6'h01;
	end
	// conversion in progress: select fall until end marker
	always_ff @(posedge clk)
	begin
		if (!rst_n || select_n || serial_out)
			conv_q <= 1'b0;
		else if ($fell(select_n))
			conv_q <= 1'b1;
	end

	sequence s_start;
		$fell(select_n) && (pdc_oe_n || pdc_o);
	endsequence
	sequence s_marker;
		##300 !serial_out_o ##[55:75] serial_out_o;
	endsequence
	property p_drive_low;
		s_start |-> ##[2:5] (!serial_out_oe_n && !serial_out_o);
	endproperty
	property p_conv_time;
		s_start |-> s_marker;
	endproperty
	property p_sck_idle;
		conv_q |-> !shift_clock;
	endproperty
	property p_release;
		$rose(select_n) |-> ##[1:5] serial_out_oe_n;
	endproperty
	property p_phase;
		$changed(shift_clock) |-> ##1 $stable(shift_clock) [*7];
	endproperty
	property p_sample_window;
		$rose(shift_clock) |-> $stable(serial_out_o) [*4];
	endproperty
	property p_frame_len;
		$rose(select_n) |-> rise_q == 5'h0d;
	endproperty
	property p_acq_gap;
		$fell(select_n) |-> high_q >= 6'h3c;
	endproperty
	property p_marker_hold;
		$rose(serial_out_o) |-> serial_out_o [*8];
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("serial_out not driven low");
	a_conv_time: assert property (p_conv_time) else $error("end marker late or early");
	a_sck_idle: assert property (p_sck_idle) else $error("shift clock ran in conversion");
	a_release: assert property (p_release) else $error("serial_out not released");
	a_phase: assert property (p_phase) else $error("shift clock phase short");
	a_sample_window: assert property (p_sample_window) else $error("data moved near rise");
	a_frame_len: assert property (p_frame_len) else $error("frame edge count wrong");
	a_acq_gap: assert property (p_acq_gap) else $error("acquisition gap short");
	a_marker_hold: assert property (p_marker_hold) else $error("marker too short");
endmodule : sar_link_asserts
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import sar_pkg::*;;
	logic clk, rst_n, clk_en, start_req, use_internal_ref, sleep_req, result_ready;
	logic res_valid, track_a, iref_a, shut_a, iref_b, shut_b, track_b, busy_a, busy_h;
	logic [9:0] ain_a, ain_b, res_data;
	logic [9:0] exp_q[$];
	integer seed;
	int num_errors, num_checks;
	localparam logic [9:0] CORNER [4] = '{10'h000, 10'h3ff, 10'h200, 10'h155};
	sar_link_if link_a();
	sar_link_if link_b();

	// ****
	// both ends, fault end, checker
	// ****
	sar_dev sar_dev_i (.clk(clk), .clk_en(clk_en), .rst_n(rst_n), .link(link_a), .analog_input(ain_a),
		.track_hold(track_a), .internal_ref_en(iref_a), .shutdown(shut_a), .busy(busy_a));
	sar_host #(.PWRUP_CYC(200)) sar_host_i (.clk(clk), .clk_en(clk_en), .rst_n(rst_n), .link(link_a),
		.start_req(start_req), .use_internal_ref(use_internal_ref), .sleep_req(sleep_req),
		.result_data(res_data), .result_valid(res_valid), .result_ready(result_ready), .busy(busy_h));
	if (1)
	begin : fault
		sar_dev sar_dev_i (.clk(clk), .clk_en(clk_en), .rst_n(rst_n), .link(link_b), .analog_input(ain_b),
			.track_hold(track_b), .internal_ref_en(iref_b), .shutdown(shut_b), .busy());
	end
	sar_link_asserts sar_link_asserts_i (.clk(clk), .rst_n(rst_n), .select_n(link_a.select_n),
		.shift_clock(link_a.shift_clock), .serial_out_o(link_a.serial_out_o),
		.serial_out_oe_n(link_a.serial_out_oe_n), .serial_out(link_a.serial_out),
		.pdc_o(link_a.pdc_o), .pdc_oe_n(link_a.pdc_oe_n));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic results;
		if (num_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick

	function automatic logic sig(input int w);
		case (w)
			0: return link_a.select_n;
			1: return res_valid;
			default: return link_b.serial_out;
		endcase
	endfunction : sig

	// marker, result msb first, sub-bits, then trailing zeros
	function automatic logic [15:0] exp_frame(input logic [9:0] v);
		return {1'b1, v, SUB_BITS_FILL, 3'h0};
	endfunction : exp_frame

	task automatic wait_sig(input int w, input logic lvl);
		int n;
		n = 0;
		while (sig(w) !== lvl && n < 4000)
		begin
			tick(1);
			n++;
		end
		if (n >= 4000)
		begin
			check("wait", 16'(lvl), 16'(sig(w)));
			results();
		end
	endtask : wait_sig

	// ****
	// host-driven conversion and result pop
	// ****
	task automatic conv(input logic [9:0] v);
		ain_a = v;
		start_req = 1'b1;
		wait_sig(0, 1'b0);
		start_req = 1'b0;
		exp_q.push_back(v);
		tick(6);
		check("track_hold", 16'h0001, 16'(track_a));
		check("busy", 16'h0001, 16'(busy_a));
		ain_a = ~v;
		wait_sig(0, 1'b1);
	endtask : conv

	task automatic pop;
		wait_sig(1, 1'b1);
		check("result", 16'(exp_q.pop_front()), 16'(res_data));
		result_ready = 1'b1;
		tick(1);
		result_ready = 1'b0;
	endtask : pop

	// ****
	// bench-driven frame on the fault end
	// ****
	task automatic frame_b(input logic [9:0] v);
		logic [15:0] got;
		got = 16'h0000;
		ain_b = v;
		link_b.select_n = 1'b0;
		tick(6);
		check("drive_low", 16'h0000, 16'({link_b.serial_out_oe_n, link_b.serial_out}));
		check("track_hold_b", 16'h0001, 16'(track_b));
		ain_b = ~v;
		wait_sig(2, 1'b1);
		for (int k = 0; k < 16; k++)
		begin
			#200;
			got[15-k] = link_b.serial_out;
			link_b.shift_clock = 1'b1;
			#200;
			link_b.shift_clock = 1'b0;
		end
		tick(1);
		link_b.select_n = 1'b1;
		tick(6);
		check("frame", exp_frame(v), got);
		check("release", 16'h0001, 16'(link_b.serial_out_oe_n));
		tick(60);
	endtask : frame_b

	initial
	begin
		logic [9:0] v;
		seed = 32'h621e_c986;
		num_errors = 0;
		num_checks = 0;
		clk_en = 1'b1;
		rst_n = 1'b0;
		start_req = 1'b0;
		use_internal_ref = 1'b1;
		sleep_req = 1'b0;
		result_ready = 1'b0;
		ain_a = 10'h000;
		ain_b = 10'h000;
		link_b.select_n = 1'b1;
		link_b.shift_clock = 1'b0;
		link_b.pdc_o = 1'b1;
		link_b.pdc_oe_n = 1'b1;
		tick(2);
		rst_n = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			v = (i < 4) ? CORNER[i] : 10'($random(seed));
			conv(v);
			pop();
		end
		conv(10'($random(seed)));
		conv(10'($random(seed)));
		start_req = 1'b1;
		tick(400);
		check("full_refuse", 16'h0001, 16'(link_a.select_n));
		start_req = 1'b0;
		pop();
		pop();
		check("empty", 16'h0000, 16'(res_valid));
		check("busy", 16'h0000, 16'({busy_a, busy_h}));
		sleep_req = 1'b1;
		tick(20);
		check("sleep", 16'h0001, 16'({link_a.pdc_level, shut_a} == 2'b01));
		sleep_req = 1'b0;
		use_internal_ref = 1'b0;
		tick(20);
		check("float", 16'h0002, 16'({link_a.pdc_float, iref_a}));
		conv(10'($random(seed)));
		pop();
		use_internal_ref = 1'b1;
		tick(20);
		check("iref", 16'h0001, 16'(iref_a));
		frame_b(10'h2a5);
		link_b.select_n = 1'b0;
		tick(100);
		link_b.select_n = 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			#200;
			link_b.shift_clock = ~link_b.shift_clock;
		end
		tick(6);
		check("abort", 16'h0001, 16'(link_b.serial_out_oe_n));
		tick(60);
		frame_b(10'($random(seed)));
		link_b.pdc_o = 1'b0;
		link_b.pdc_oe_n = 1'b0;
		tick(4);
		link_b.select_n = 1'b0;
		tick(20);
		check("shut_ignore", 16'h0003, 16'({link_b.serial_out_oe_n, shut_b}));
		link_b.select_n = 1'b1;
		link_b.pdc_oe_n = 1'b1;
		tick(6);
		check("ext_ref", 16'h0000, 16'({iref_b, shut_b}));
		tick(170);
		frame_b(10'($random(seed)));
		results();
	end
endmodule : testbench
`default_nettype wire
